// ===== core/nibble_cpu_core.sv
// nibble execution core: xor/inc/rotate, port, transfer and jump ops
// assumes program memory is loaded over apb before run is set; port
// pins are synchronous to pclk
`timescale 1ns/1ps

module nibble_cpu_core #(
  parameter int ROM_WORDS = 2048,
  parameter int PAGE_SEL_W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] port_in,
  input wire logic status_flag,
  output logic [31:0] port_out,
  output logic trap_reset
);

  localparam int AW = $clog2(ROM_WORDS);

  logic [9:0] prog_mem [ROM_WORDS];
  logic [3:0] work_reg [32];
  logic [3:0] acc;
  logic carry;
  logic [AW-1:0] pc;
  logic run;
  logic core_clear;
  logic [PAGE_SEL_W-1:0] page_sel;
  logic [AW-1:0] prog_addr;

  logic [9:0] w0;
  logic [9:0] w1;
  logic [9:0] tw;
  logic [AW-1:0] pc_plus1;
  logic [AW-1:0] pc_plus2;
  logic [AW-1:0] table_addr;
  logic [AW-1:0] target;
  logic jump_page;
  logic [3:0] reg_val;
  logic [3:0] pinfo;
  logic [3:0] pval;
  logic exec;

  logic [3:0] next_acc;
  logic next_carry;
  logic [AW-1:0] next_pc;
  logic trap;
  logic reg_we;
  logic [4:0] reg_idx;
  logic pair_we;
  logic [3:0] pair_idx;
  logic [7:0] pair_data;
  logic port_we;
  logic port_pair_we;
  logic [7:0] port_pair_data;

  // apb slave
  logic setup;
  logic wr;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite;
  assign addr_ok = (paddr == nibble_cpu_pkg::OFS_CTRL) ||
                   (paddr == nibble_cpu_pkg::OFS_PAGE_SEL) ||
                   (paddr == nibble_cpu_pkg::OFS_STATUS) ||
                   (paddr == nibble_cpu_pkg::OFS_PROG_ADDR) ||
                   (paddr == nibble_cpu_pkg::OFS_PROG_DATA);

  always_comb begin
    rd_mux = nibble_cpu_pkg::RST_WORD;
    case (paddr)
      nibble_cpu_pkg::OFS_CTRL: begin
        rd_mux[nibble_cpu_pkg::CTRL_RUN_BIT] = run;
      end
      nibble_cpu_pkg::OFS_PAGE_SEL: begin
        rd_mux[PAGE_SEL_W-1:0] = page_sel;
      end
      nibble_cpu_pkg::OFS_STATUS: begin
        rd_mux[3:0] = acc;
        rd_mux[nibble_cpu_pkg::STAT_CARRY_BIT] = carry;
        rd_mux[nibble_cpu_pkg::STAT_PC_LSB +: AW] = pc;
      end
      nibble_cpu_pkg::OFS_PROG_ADDR: begin
        rd_mux[AW-1:0] = prog_addr;
      end
      nibble_cpu_pkg::OFS_PROG_DATA: begin
        rd_mux[9:0] = prog_mem[prog_addr];
      end
      default: begin
        rd_mux = nibble_cpu_pkg::RST_WORD;
      end
    endcase
  end

  // answer one cycle after setup, data and error registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= nibble_cpu_pkg::RST_WORD;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
      prdata <= (setup && !pwrite) ? rd_mux : nibble_cpu_pkg::RST_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      core_clear <= 1'b0;
      page_sel <= '0;
    end else begin
      core_clear <= wr && (paddr == nibble_cpu_pkg::OFS_CTRL) &&
                    pwdata[nibble_cpu_pkg::CTRL_CLEAR_BIT];
      if (wr && paddr == nibble_cpu_pkg::OFS_CTRL) begin
        run <= pwdata[nibble_cpu_pkg::CTRL_RUN_BIT];
      end
      if (wr && paddr == nibble_cpu_pkg::OFS_PAGE_SEL) begin
        page_sel <= pwdata[PAGE_SEL_W-1:0];
      end
    end
  end

  // load pointer steps after each data write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_addr <= '0;
    end else if (wr && paddr == nibble_cpu_pkg::OFS_PROG_ADDR) begin
      prog_addr <= pwdata[AW-1:0];
    end else if (wr && paddr == nibble_cpu_pkg::OFS_PROG_DATA) begin
      prog_addr <= prog_addr + AW'(1);
    end
  end

  // two 1k pages for the default size
  always_ff @(posedge pclk) begin
    if (wr && paddr == nibble_cpu_pkg::OFS_PROG_DATA) begin
      prog_mem[prog_addr] <= pwdata[9:0];
    end
  end

  // fetch and operand selection
  assign exec = run & ~core_clear;
  assign pc_plus1 = pc + AW'(1);
  assign pc_plus2 = pc + AW'(2);
  assign w0 = prog_mem[pc];
  assign w1 = prog_mem[pc_plus1];
  assign table_addr = AW'({page_sel, work_reg[16], work_reg[0]});
  assign tw = prog_mem[table_addr];
  // page bit is not one opcode bit: decode the page 1 forms by word
  assign jump_page = (w0 == nibble_cpu_pkg::OP_JMP_P1) ||
                     (w0 == nibble_cpu_pkg::OP_JC_P1) ||
                     (w0 == nibble_cpu_pkg::OP_JNC_P1) ||
                     (w0 == nibble_cpu_pkg::OP_JF_P1) ||
                     (w0 == nibble_cpu_pkg::OP_JNF_P1);
  // address word order a9 a7 a6 a5 a4 a8 a3..a0
  assign target = AW'({jump_page, w1[9], w1[4], w1[8:5], w1[3:0]});
  assign reg_val = work_reg[{w0[5], w0[3:0]}];
  assign pinfo = nibble_cpu_pkg::port_slot(w0[5], w0[2:0]);
  assign pval = pinfo[3] ? port_in[pinfo[2:0]*4 +: 4] : 4'h0;

  always_comb begin
    next_acc = acc;
    next_carry = carry;
    next_pc = pc_plus1;
    trap = 1'b0;
    reg_we = 1'b0;
    reg_idx = {w0[5], w0[3:0]};
    pair_we = 1'b0;
    pair_idx = w0[3:0];
    pair_data = w1[7:0];
    port_we = 1'b0;
    port_pair_we = 1'b0;
    port_pair_data = w1[7:0];
    if (w0[9:6] == nibble_cpu_pkg::GRP_XOR && !w0[4]) begin
      next_acc = acc ^ reg_val;
      next_carry = acc[3] & reg_val[3];
    end else if (w0[4:3] == 2'b11 && w0[9:6] != 4'h3) begin
      case (w0[9:6])
        nibble_cpu_pkg::GRP_XOR: begin
          next_acc = acc ^ pval;
          next_carry = acc[3] & pval[3];
        end
        nibble_cpu_pkg::GRP_AND: begin
          next_acc = acc & pval;
          next_carry = acc[3] & pval[3];
        end
        nibble_cpu_pkg::GRP_OR: begin
          next_acc = acc | pval;
          next_carry = 1'b0;
        end
        nibble_cpu_pkg::GRP_IN: begin
          next_acc = pval;
          next_carry = 1'b0;
        end
        nibble_cpu_pkg::GRP_OUT: begin
          port_we = pinfo[3];
        end
        default: begin
          next_acc = acc;
        end
      endcase
    end else if (w0[9:6] == nibble_cpu_pkg::GRP_IN && !w0[4]) begin
      next_acc = reg_val;
      next_carry = 1'b0;
    end else if (w0[9:6] == nibble_cpu_pkg::GRP_OUT && !w0[4]) begin
      reg_we = 1'b1;
    end else if (w0[9:3] == nibble_cpu_pkg::PFX_OUT_IMM) begin
      port_pair_we = pinfo[3];
      next_pc = pc_plus2;
    end else if (w0[9:4] == nibble_cpu_pkg::PFX_PAIR_IMM) begin
      pair_we = 1'b1;
      next_pc = pc_plus2;
    end else if (w0[9:4] == nibble_cpu_pkg::PFX_PAIR_IND) begin
      pair_we = (w0[3:0] != 4'h0);
      pair_data = tw[7:0];
    end else begin
      case (w0)
        nibble_cpu_pkg::OP_XOR_ROM_H: begin
          next_acc = acc ^ tw[7:4];
          next_carry = acc[3] & tw[7];
        end
        nibble_cpu_pkg::OP_XOR_ROM_L: begin
          next_acc = acc ^ tw[3:0];
          next_carry = acc[3] & tw[3];
        end
        nibble_cpu_pkg::OP_XOR_IMM: begin
          next_acc = acc ^ w1[3:0];
          next_carry = acc[3] & w1[3];
          next_pc = pc_plus2;
        end
        nibble_cpu_pkg::OP_INC: begin
          next_acc = acc + 4'h1;
          next_carry = (acc == 4'hF);
        end
        nibble_cpu_pkg::OP_ROT: begin
          next_acc = {acc[2:0], acc[3]};
          next_carry = acc[3];
        end
        nibble_cpu_pkg::OP_ROT_TRAP: begin
          trap = (acc == 4'h0);
          next_acc = {acc[2:0], acc[3]};
          next_carry = acc[3];
        end
        nibble_cpu_pkg::OP_LD_ROM_H: begin
          next_acc = tw[7:4];
          next_carry = 1'b0;
        end
        nibble_cpu_pkg::OP_LD_ROM_L: begin
          next_acc = tw[3:0];
          next_carry = 1'b0;
        end
        nibble_cpu_pkg::OP_LD_IMM: begin
          next_acc = w1[3:0];
          next_carry = 1'b0;
          next_pc = pc_plus2;
        end
        nibble_cpu_pkg::OP_JMP_P0, nibble_cpu_pkg::OP_JMP_P1: begin
          next_pc = target;
        end
        nibble_cpu_pkg::OP_JC_P0, nibble_cpu_pkg::OP_JC_P1: begin
          next_pc = carry ? target : pc_plus2;
        end
        nibble_cpu_pkg::OP_JNC_P0, nibble_cpu_pkg::OP_JNC_P1: begin
          next_pc = !carry ? target : pc_plus2;
        end
        nibble_cpu_pkg::OP_JF_P0, nibble_cpu_pkg::OP_JF_P1: begin
          next_pc = status_flag ? target : pc_plus2;
        end
        nibble_cpu_pkg::OP_JNF_P0, nibble_cpu_pkg::OP_JNF_P1: begin
          next_pc = !status_flag ? target : pc_plus2;
        end
        default: begin
          next_pc = pc_plus1;
        end
      endcase
    end
  end

  // internal trap resets pc, acc and carry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= nibble_cpu_pkg::RST_NIBBLE;
      carry <= 1'b0;
      pc <= '0;
      trap_reset <= 1'b0;
    end else begin
      trap_reset <= exec & trap;
      if (core_clear || (exec && trap)) begin
        acc <= nibble_cpu_pkg::RST_NIBBLE;
        carry <= 1'b0;
        pc <= '0;
      end else if (exec) begin
        acc <= next_acc;
        carry <= next_carry;
        pc <= next_pc;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        work_reg[i] <= nibble_cpu_pkg::RST_NIBBLE;
      end
    end else if (exec) begin
      if (reg_we) begin
        work_reg[reg_idx] <= acc;
      end
      if (pair_we) begin
        work_reg[{1'b1, pair_idx}] <= pair_data[7:4];
        work_reg[{1'b0, pair_idx}] <= pair_data[3:0];
      end
    end
  end

  // bank 1 nibble of a port pair carries the high half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out <= nibble_cpu_pkg::RST_WORD;
    end else if (exec) begin
      if (port_we) begin
        port_out[pinfo[2:0]*4 +: 4] <= acc;
      end
      if (port_pair_we) begin
        port_out[{1'b1, pinfo[1:0]}*4 +: 4] <= port_pair_data[7:4];
        port_out[{1'b0, pinfo[1:0]}*4 +: 4] <= port_pair_data[3:0];
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_xor_reg_carry: assert property (
    exec && w0[9:6] == nibble_cpu_pkg::GRP_XOR && !w0[4]
    |=> acc == ($past(acc) ^ $past(reg_val)) &&
        carry == ($past(acc[3]) & $past(reg_val[3])))
    else $error("xor register result or carry wrong");
  a_xor_rom_carry: assert property (
    exec && w0 == nibble_cpu_pkg::OP_XOR_ROM_H
    |=> carry == ($past(acc[3]) & $past(tw[7])))
    else $error("xor rom high carry wrong");
  a_xor_imm_skip: assert property (
    exec && w0 == nibble_cpu_pkg::OP_XOR_IMM
    |=> acc == ($past(acc) ^ $past(w1[3:0])) &&
        pc == AW'($past(pc) + AW'(2)))
    else $error("xor immediate wrong");
  a_inc_carry: assert property (
    exec && w0 == nibble_cpu_pkg::OP_INC
    |=> acc == 4'($past(acc) + 4'h1) && carry == (acc == 4'h0))
    else $error("increment or carry wrong");
  a_rotate_left: assert property (
    exec && w0 == nibble_cpu_pkg::OP_ROT
    |=> acc == {$past(acc[2:0]), $past(acc[3])} &&
        carry == $past(acc[3]))
    else $error("rotate wrong");
  a_trap_zero: assert property (
    exec && w0 == nibble_cpu_pkg::OP_ROT_TRAP && acc == 4'h0
    |=> trap_reset && pc == '0)
    else $error("zero rotate did not trap");
  a_port_read: assert property (
    exec && w0[9:6] == nibble_cpu_pkg::GRP_IN && w0[4:3] == 2'b11
    |=> acc == $past(pval) && !carry)
    else $error("port read wrong");
  a_port_write: assert property (
    exec && port_we
    |=> port_out[$past(pinfo[2:0])*4 +: 4] == $past(acc) &&
        carry == $past(carry))
    else $error("port latch wrong");
  a_jump_abs: assert property (
    exec && w0 == nibble_cpu_pkg::OP_JMP_P0
    |=> pc == AW'({1'b0, $past(w1[9]), $past(w1[4]), $past(w1[8:5]),
                   $past(w1[3:0])}))
    else $error("absolute jump wrong");
  a_jump_clear_page: assert property (
    exec && w0 == nibble_cpu_pkg::OP_JNC_P0 && !carry
    |=> pc == AW'({1'b0, $past(w1[9]), $past(w1[4]), $past(w1[8:5]),
                   $past(w1[3:0])}))
    else $error("carry clear jump target wrong");
  a_jump_carry: assert property (
    exec && w0 == nibble_cpu_pkg::OP_JC_P0 && !carry
    |=> pc == AW'($past(pc) + AW'(2)))
    else $error("carry jump fall-through wrong");
  a_apb_answer: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  c_trap: cover property (exec && trap);
  c_jump_taken: cover property (exec && w0 == nibble_cpu_pkg::OP_JC_P1 &&
                                carry);
  c_port_pair: cover property (exec && port_pair_we);
  c_prog_load: cover property (wr && paddr == nibble_cpu_pkg::OFS_PROG_DATA);

endmodule

// ===== core/nibble_cpu_pkg.sv
// constants, opcodes and register map of the nibble execution core
// assumes a 10-bit program word and an apb register window
package nibble_cpu_pkg;

  // apb register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_PAGE_SEL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PROG_ADDR = 12'h00C;
  localparam logic [11:0] OFS_PROG_DATA = 12'h010;

  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int STAT_CARRY_BIT = 4;
  localparam int STAT_PC_LSB = 16;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // opcode groups, bits 9..6
  localparam logic [3:0] GRP_XOR = 4'hA;
  localparam logic [3:0] GRP_AND = 4'hD;
  localparam logic [3:0] GRP_OR = 4'hE;
  localparam logic [3:0] GRP_IN = 4'hF;
  localparam logic [3:0] GRP_OUT = 4'h2;

  // prefixes of register-pair and port-pair forms
  localparam logic [6:0] PFX_OUT_IMM = 7'h1B;
  localparam logic [5:0] PFX_PAIR_IMM = 6'h0C;
  localparam logic [5:0] PFX_PAIR_IND = 6'h0E;

  // whole-word opcodes
  localparam logic [9:0] OP_XOR_ROM_H = 10'h290;
  localparam logic [9:0] OP_XOR_ROM_L = 10'h2B0;
  localparam logic [9:0] OP_XOR_IMM = 10'h2B1;
  localparam logic [9:0] OP_INC = 10'h293;
  localparam logic [9:0] OP_ROT = 10'h3F3;
  localparam logic [9:0] OP_ROT_TRAP = 10'h3D3;
  localparam logic [9:0] OP_LD_ROM_H = 10'h3D0;
  localparam logic [9:0] OP_LD_ROM_L = 10'h3F0;
  localparam logic [9:0] OP_LD_IMM = 10'h3F1;
  localparam logic [9:0] OP_JMP_P0 = 10'h111;
  localparam logic [9:0] OP_JMP_P1 = 10'h131;
  localparam logic [9:0] OP_JC_P0 = 10'h191;
  localparam logic [9:0] OP_JC_P1 = 10'h151;
  localparam logic [9:0] OP_JNC_P0 = 10'h1B1;
  localparam logic [9:0] OP_JNC_P1 = 10'h171;
  localparam logic [9:0] OP_JF_P0 = 10'h1D1;
  localparam logic [9:0] OP_JF_P1 = 10'h211;
  localparam logic [9:0] OP_JNF_P0 = 10'h1F1;
  localparam logic [9:0] OP_JNF_P1 = 10'h231;

  // maps bank and port index 0,1,3,4 to {valid, slot[2:0]}
  function automatic logic [3:0] port_slot(input logic bank,
                                           input logic [2:0] n);
    logic [3:0] r;
    case (n)
      3'h0: r = {1'b1, bank, 2'h0};
      3'h1: r = {1'b1, bank, 2'h1};
      3'h3: r = {1'b1, bank, 2'h2};
      3'h4: r = {1'b1, bank, 2'h3};
      default: r = 4'h0;
    endcase
    return r;
  endfunction

endpackage

// ===== testbench/nibble_cpu_instruction_exec_tb_top.sv
// self-checking bench for the nibble execution core
// assumes the core package and core are compiled first; bench drives
// apb, port pins and the status flag itself
`timescale 1ns/1ps

module nibble_cpu_instruction_exec_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] port_in = 32'h0000_0000;
  logic status_flag = 1'b0;
  logic [31:0] port_out;
  logic trap_reset;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int trap_cnt = 0;
  logic [9:0] prog[$];
  logic [31:0] rd;
  logic se;

  always #2 pclk = ~pclk;

  nibble_cpu_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_in(port_in), .status_flag(status_flag), .port_out(port_out),
    .trap_reset(trap_reset));

  task automatic final_report();
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard and trap pulse counter
  always @(posedge pclk) begin
    cycles++;
    if (trap_reset === 1'b1) trap_cnt++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic em(input logic [9:0] w);
    prog.push_back(w);
  endtask

  task automatic li(input logic [3:0] d);
    em(nibble_cpu_pkg::OP_LD_IMM);
    em({6'h00, d});
  endtask

  function automatic logic [9:0] ja(input logic [9:0] a);
    return {a[9], a[7:4], a[8], a[3:0]};
  endfunction

  task automatic poke(input logic [10:0] a, input logic [9:0] d);
    apb(1'b1, nibble_cpu_pkg::OFS_PROG_ADDR, {21'h0, a});
    apb(1'b1, nibble_cpu_pkg::OFS_PROG_DATA, {22'h0, d});
  endtask

  // load program plus a self jump, run, wait for pc, check state
  task automatic exec(input string nm, input logic [3:0] ea,
                      input logic ec, input logic [10:0] epc);
    int n;
    logic [10:0] hpc;
    hpc = 11'(prog.size());
    em(nibble_cpu_pkg::OP_JMP_P0);
    em(ja(hpc[9:0]));
    if (epc === 11'h7FF) epc = hpc;
    apb(1'b1, nibble_cpu_pkg::OFS_CTRL, 32'h0000_0000);
    apb(1'b1, nibble_cpu_pkg::OFS_PROG_ADDR, 32'h0000_0000);
    foreach (prog[i]) begin
      apb(1'b1, nibble_cpu_pkg::OFS_PROG_DATA, {22'h0, prog[i]});
    end
    apb(1'b1, nibble_cpu_pkg::OFS_CTRL, 32'h0000_0002);
    apb(1'b1, nibble_cpu_pkg::OFS_CTRL, 32'h0000_0001);
    n = 0;
    apb(1'b0, nibble_cpu_pkg::OFS_STATUS, 32'h0000_0000);
    while (rd[26:16] !== epc && n < 40) begin
      apb(1'b0, nibble_cpu_pkg::OFS_STATUS, 32'h0000_0000);
      n++;
    end
    check({nm, " pc"}, {21'h0, rd[26:16]}, {21'h0, epc});
    check({nm, " acc"}, {28'h0, rd[3:0]}, {28'h0, ea});
    check({nm, " carry"}, {31'h0, rd[4]}, {31'h0, ec});
    prog.delete();
  endtask

  task automatic sc_bus();
    apb(1'b0, nibble_cpu_pkg::OFS_STATUS, 32'h0000_0000);
    check("status reset", rd, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check("unmapped err", {31'h0, se}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, nibble_cpu_pkg::OFS_PAGE_SEL, 32'h0000_0005);
    apb(1'b0, nibble_cpu_pkg::OFS_PAGE_SEL, 32'h0000_0000);
    check("page select", rd, 32'h0000_0005);
  endtask

  task automatic sc_alu();
    li(4'h8);
    em({4'h2, 2'b00, 4'h3});
    li(4'hF);
    em({4'hA, 2'b00, 4'h3});
    exec("xor reg", 4'h7, 1'b1, 11'h7FF);
    li(4'hC);
    em(nibble_cpu_pkg::OP_XOR_IMM);
    em(10'h009);
    exec("xor imm", 4'h5, 1'b1, 11'h7FF);
    li(4'hF);
    em(nibble_cpu_pkg::OP_INC);
    exec("inc wrap", 4'h0, 1'b1, 11'h7FF);
    li(4'hE);
    em(nibble_cpu_pkg::OP_INC);
    exec("inc", 4'hF, 1'b0, 11'h7FF);
    li(4'h9);
    em(nibble_cpu_pkg::OP_ROT);
    exec("rotate", 4'h3, 1'b1, 11'h7FF);
    li(4'hF);
    em(nibble_cpu_pkg::OP_INC);
    em({4'hF, 2'b00, 4'h3});
    exec("reg to acc", 4'h8, 1'b0, 11'h7FF);
  endtask

  task automatic sc_rom();
    poke(11'h040, 10'h3A5);
    poke(11'h440, 10'h16C);
    apb(1'b1, nibble_cpu_pkg::OFS_PAGE_SEL, 32'h0000_0000);
    em(10'h0C0);
    em(10'h040);
    li(4'h8);
    em(nibble_cpu_pkg::OP_XOR_ROM_H);
    exec("xor rom hi", 4'h2, 1'b1, 11'h7FF);
    em(10'h0C0);
    em(10'h040);
    em(nibble_cpu_pkg::OP_LD_ROM_L);
    exec("rom lo", 4'h5, 1'b0, 11'h7FF);
    apb(1'b1, nibble_cpu_pkg::OFS_PAGE_SEL, 32'h0000_0004);
    em(10'h0C0);
    em(10'h040);
    em(nibble_cpu_pkg::OP_LD_ROM_L);
    exec("rom lo pg1", 4'hC, 1'b0, 11'h7FF);
    em(10'h0C0);
    em(10'h040);
    em({6'h0E, 4'h3});
    em({4'hF, 2'b10, 4'h3});
    em({4'hA, 2'b00, 4'h3});
    exec("pair ind", 4'hA, 1'b0, 11'h7FF);
    em(10'h0C7);
    em(10'h096);
    em({4'hF, 2'b10, 4'h7});
    em({4'hA, 2'b00, 4'h7});
    exec("pair imm", 4'hF, 1'b0, 11'h7FF);
  endtask

  task automatic sc_port();
    port_in <= 32'h1234_9A5C;
    li(4'hF);
    em(nibble_cpu_pkg::OP_INC);
    em({4'hF, 1'b1, 2'b11, 3'h3});
    exec("port in", 4'h2, 1'b0, 11'h7FF);
    li(4'hF);
    em({4'hD, 1'b0, 2'b11, 3'h3});
    exec("port and", 4'hA, 1'b1, 11'h7FF);
    li(4'hC);
    em({4'hA, 1'b0, 2'b11, 3'h4});
    exec("port xor", 4'h5, 1'b1, 11'h7FF);
    li(4'hF);
    em(nibble_cpu_pkg::OP_INC);
    em({4'hE, 1'b0, 2'b11, 3'h0});
    exec("port or", 4'hC, 1'b0, 11'h7FF);
    em({7'h1B, 3'h1});
    em(10'h0A7);
    li(4'h8);
    em(nibble_cpu_pkg::OP_ROT);
    em({4'h2, 1'b1, 2'b11, 3'h4});
    exec("port out", 4'h1, 1'b1, 11'h7FF);
    check("port latch", port_out, 32'h10A0_0070);
  endtask

  task automatic sc_jump();
    logic [9:0] tg[2];
    tg = '{10'h123, 10'h2D3};
    li(4'hF);
    em(nibble_cpu_pkg::OP_INC);
    em(nibble_cpu_pkg::OP_JNC_P0);
    em(ja(10'h007));
    em(nibble_cpu_pkg::OP_JC_P0);
    em(ja(10'h009));
    li(4'h5);
    exec("carry set", 4'h0, 1'b1, 11'h009);
    li(4'hE);
    em(nibble_cpu_pkg::OP_INC);
    em(nibble_cpu_pkg::OP_JC_P0);
    em(ja(10'h007));
    em(nibble_cpu_pkg::OP_JNC_P0);
    em(ja(10'h009));
    li(4'h5);
    exec("carry clr", 4'hF, 1'b0, 11'h009);
    for (int f = 0; f < 2; f++) begin
      status_flag <= f[0];
      em(f[0] ? nibble_cpu_pkg::OP_JNF_P0 : nibble_cpu_pkg::OP_JF_P0);
      em(ja(10'h004));
      em(f[0] ? nibble_cpu_pkg::OP_JF_P0 : nibble_cpu_pkg::OP_JNF_P0);
      em(ja(10'h006));
      li(4'h5);
      exec("status jump", 4'h0, 1'b0, 11'h006);
    end
    for (int k = 0; k < 2; k++) begin
      poke({1'b1, tg[k]}, nibble_cpu_pkg::OP_JMP_P1);
      poke({1'b1, tg[k]} + 11'h001, ja(tg[k]));
      em(nibble_cpu_pkg::OP_JMP_P1);
      em(ja(tg[k]));
      exec("far jump", 4'h0, 1'b0, {1'b1, tg[k]});
    end
  endtask

  task automatic sc_trap();
    li(4'h9);
    em(nibble_cpu_pkg::OP_ROT_TRAP);
    trap_cnt = 0;
    exec("rot nz", 4'h3, 1'b1, 11'h7FF);
    check("no trap", trap_cnt, 32'h0000_0000);
    port_in <= 32'h0000_0000;
    em({4'hF, 1'b0, 2'b11, 3'h0});
    em(nibble_cpu_pkg::OP_ROT_TRAP);
    fork
      begin
        repeat (40) @(posedge pclk);
        port_in <= 32'h0000_0003;
      end
    join_none
    trap_cnt = 0;
    exec("trap exit", 4'h6, 1'b0, 11'h7FF);
    check("trap seen", {31'h0, trap_cnt != 0}, 32'h0000_0001);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    sc_bus();
    sc_alu();
    sc_rom();
    sc_port();
    sc_jump();
    sc_trap();
    final_report();
  end
endmodule
